// file: dhp_axis_model.sv
`timescale 1ns/1ps
`default_nettype none
module dhp_axis_model #(
	parameter int LIM_NEG = 8,
	parameter int LIM_POS = 200,
	parameter int SW_LO = 100,
	parameter int SW_HI = 120,
	parameter int IDX_PITCH = 16
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// motion command
	input wire logic moveEn,
	input wire logic moveDir,
	// bench positioning
	input wire logic setPos,
	input wire logic [31:0] setVal,
	// axis signals
	output logic [31:0] encCount,
	output logic indexPulse,
	output logic limNeg,
	output logic limPos,
	output logic homeSw
);
	// one count per cycle at both speeds, so every edge lands on an exact count
	always_ff @(posedge mclk) begin
		if (!rstn)
			encCount <= 32'h0000_0000;
		else if (setPos)
			encCount <= setVal;
		else if (moveEn)
			encCount <= moveDir ? encCount + 32'h0000_0001 : encCount - 32'h0000_0001;
	end
	assign limNeg = $signed(encCount) <= LIM_NEG;
	assign limPos = $signed(encCount) >= LIM_POS;
	assign homeSw = $signed(encCount) >= SW_LO && $signed(encCount) <= SW_HI;
	assign indexPulse = (encCount % IDX_PITCH) == 0;
endmodule : dhp_axis_model
`default_nettype wire

// file: dhp_homing_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dhp_homing_monitor #(
	parameter int MS_CYCLES = dhp_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// object access port
	input wire logic [15:0] objIndex,
	input wire logic objWrite,
	input wire logic objRead,
	input wire logic [31:0] objWrData,
	output logic [31:0] objRdData,
	output logic objAck,
	output logic objError,
	// axis hardware
	input wire logic [31:0] encCount,
	input wire logic indexPulse,
	input wire logic limNeg,
	input wire logic limPos,
	input wire logic homeSw,
	// trajectory generator, user units
	input wire logic [31:0] demandPos,
	// configuration
	input wire logic [4:0] posShift,
	input wire logic [15:0] kpGain,
	input wire logic [31:0] effortMax,
	input wire logic [31:0] effortStepMax,
	input wire logic homeStart,
	// motion command
	output logic moveEn,
	output logic moveDir,
	output logic moveFast,
	output logic signed [31:0] controlEffort,
	// status
	output logic [15:0] statusWord,
	output logic homingActive
);
	typedef enum {HS_IDLE, HS_FIND, HS_PRE, HS_EDGE, HS_INDEX} dhp_home_state_e;

	// software objects
	logic [31:0] band;
	logic [15:0] timeoutMs;
	logic [31:0] homeOffset;
	logic signed [7:0] homingMethod;
	// readback copies
	logic [31:0] demandReg;
	logic [31:0] measIncReg;
	logic [31:0] measUserReg;

	// homing
	dhp_home_state_e state;
	dhp_home_state_e next_state;
	logic next_dir;
	logic captureNow;
	logic signed [7:0] activeMethod;
	dhp_pkg::dhp_method_s startCfg;
	dhp_pkg::dhp_method_s cfg;
	logic startSig;
	logic curSig;
	logic limAhead;
	logic [31:0] zeroPos;
	logic homingDone;

	// tracking supervision
	logic [31:0] demandInc;
	logic signed [31:0] trackErr;
	logic [31:0] trackAbs;
	logic outOfBand;
	logic [31:0] msDiv;
	logic [16:0] msElapsed;
	logic followErr;

	// the switch that a method watches
	function automatic logic pickSignal(input dhp_pkg::dhp_kind_e k, input logic ln,
		input logic lp, input logic hs);
		logic s;
		s = hs;
		if (k == dhp_pkg::HK_LIMNEG) begin
			s = ln;
		end else if (k == dhp_pkg::HK_LIMPOS) begin
			s = lp;
		end
		return s;
	endfunction : pickSignal

	assign startCfg = dhp_pkg::decodeMethod(homingMethod);
	assign cfg = dhp_pkg::decodeMethod(activeMethod);
	assign startSig = pickSignal(startCfg.kind, limNeg, limPos, homeSw);
	assign curSig = pickSignal(cfg.kind, limNeg, limPos, homeSw);
	assign limAhead = (moveDir == dhp_pkg::DIR_RIGHT) ? limPos : limNeg;

	// homing sequencer
	always_comb begin
		next_state = state;
		next_dir = moveDir;
		captureNow = 1'b0;
		unique case (state)
			HS_IDLE: begin
				if (homeStart) begin
					unique case (startCfg.kind)
						dhp_pkg::HK_NONE: next_state = HS_IDLE;
						dhp_pkg::HK_CURPOS: captureNow = 1'b1;
						dhp_pkg::HK_INDEX: begin
							next_state = HS_INDEX;
							next_dir = startCfg.dirFinal;
						end
						dhp_pkg::HK_MOMENT: begin
							if (!startSig) begin
								next_state = HS_FIND;
								next_dir = startCfg.dirInit;
							end else if (startCfg.lvlFinal) begin
								next_state = HS_PRE;
								next_dir = ~startCfg.dirFinal;
							end else begin
								next_state = HS_EDGE;
								next_dir = startCfg.dirFinal;
							end
						end
						default: begin
							// limit and level switches: leave the final level first if the axis starts at it
							if (startSig == startCfg.lvlFinal) begin
								next_state = HS_PRE;
								next_dir = ~startCfg.dirFinal;
							end else begin
								next_state = HS_EDGE;
								next_dir = startCfg.dirFinal;
							end
						end
					endcase
				end
			end
			HS_FIND: begin
				if (curSig) begin
					next_state = cfg.lvlFinal ? HS_PRE : HS_EDGE;
					next_dir = cfg.lvlFinal ? ~cfg.dirFinal : cfg.dirFinal;
				end else if (limAhead) begin
					next_dir = ~moveDir;
				end
			end
			HS_PRE: begin
				if (curSig != cfg.lvlFinal) begin
					next_state = HS_EDGE;
					next_dir = cfg.dirFinal;
				end else if (cfg.kind == dhp_pkg::HK_MOMENT && limAhead) begin
					next_dir = ~moveDir;
				end
			end
			HS_EDGE: begin
				if (curSig == cfg.lvlFinal) begin
					if (cfg.useIdx) begin
						next_state = HS_INDEX;
					end else begin
						next_state = HS_IDLE;
						captureNow = 1'b1;
					end
				end
			end
			HS_INDEX: begin
				if (indexPulse) begin
					next_state = HS_IDLE;
					captureNow = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state <= HS_IDLE;
			moveDir <= dhp_pkg::DIR_RIGHT;
			moveEn <= 1'b0;
			moveFast <= 1'b0;
			homingActive <= 1'b0;
			activeMethod <= dhp_pkg::RST_METHOD;
		end else begin
			state <= next_state;
			moveDir <= next_dir;
			// motion ends in the cycle after capture
			moveEn <= (next_state != HS_IDLE);
			// switch search at fast speed, edge and index approach slow
			moveFast <= (next_state == HS_FIND) || (next_state == HS_PRE);
			homingActive <= (next_state != HS_IDLE);
			if (state == HS_IDLE && homeStart) begin
				activeMethod <= homingMethod;
			end
		end
	end

	// home capture and zero point
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			zeroPos <= dhp_pkg::RST_WORD;
			homingDone <= 1'b0;
		end else if (captureNow) begin
			zeroPos <= encCount + dhp_pkg::toInc(homeOffset, posShift);
			homingDone <= 1'b1;
		end else if (state == HS_IDLE && homeStart && startCfg.kind != dhp_pkg::HK_NONE) begin
			homingDone <= 1'b0;
		end
	end

	// tracking supervision
	always_comb begin
		demandInc = dhp_pkg::toInc(demandPos, posShift) + zeroPos;
		trackErr = signed'(encCount - demandInc);
		trackAbs = trackErr[31] ? 32'(-trackErr) : 32'(trackErr);
		outOfBand = trackAbs > dhp_pkg::toInc(band, posShift);
	end

	// the ms time base restarts at each excursion so the first ms is whole
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			msDiv <= dhp_pkg::RST_WORD;
			msElapsed <= '0;
		end else if (!outOfBand) begin
			msDiv <= dhp_pkg::RST_WORD;
			msElapsed <= '0;
		end else if (msDiv == 32'(MS_CYCLES - 1)) begin
			msDiv <= dhp_pkg::RST_WORD;
			if (!msElapsed[16]) begin
				msElapsed <= msElapsed + 17'h0_0001;
			end
		end else begin
			msDiv <= msDiv + 32'h0000_0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			followErr <= 1'b0;
		end else begin
			followErr <= outOfBand && (msElapsed > {1'b0, timeoutMs});
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			statusWord <= 16'h0000;
		end else begin
			statusWord <= 16'h0000;
			statusWord[dhp_pkg::STAT_FOLLOW_ERR] <= followErr;
			statusWord[dhp_pkg::STAT_HOME_DONE] <= homingDone;
		end
	end

	// readback copies of the live positions
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			demandReg <= dhp_pkg::RST_WORD;
			measIncReg <= dhp_pkg::RST_WORD;
			measUserReg <= dhp_pkg::RST_WORD;
		end else begin
			demandReg <= demandPos;
			measIncReg <= encCount;
			measUserReg <= 32'(signed'(encCount - zeroPos) >>> posShift);
		end
	end

	// object writes; read-only and unknown indices are refused
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			band <= dhp_pkg::RST_WORD;
			timeoutMs <= dhp_pkg::RST_TIMEOUT;
			homeOffset <= dhp_pkg::RST_WORD;
			homingMethod <= dhp_pkg::RST_METHOD;
		end else if (objWrite) begin
			unique case (objIndex)
				dhp_pkg::IDX_BAND: band <= objWrData;
				dhp_pkg::IDX_TIMEOUT: timeoutMs <= objWrData[15:0];
				dhp_pkg::IDX_HOME_OFFSET: homeOffset <= objWrData;
				dhp_pkg::IDX_METHOD: homingMethod <= objWrData[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			objRdData <= dhp_pkg::RST_WORD;
			objAck <= 1'b0;
			objError <= 1'b0;
		end else begin
			objAck <= 1'b0;
			objError <= 1'b0;
			if (objWrite) begin
				unique case (objIndex)
					dhp_pkg::IDX_BAND, dhp_pkg::IDX_TIMEOUT,
					dhp_pkg::IDX_HOME_OFFSET, dhp_pkg::IDX_METHOD: objAck <= 1'b1;
					default: objError <= 1'b1;
				endcase
			end else if (objRead) begin
				objAck <= 1'b1;
				unique case (objIndex)
					dhp_pkg::IDX_DEMAND: objRdData <= demandReg;
					dhp_pkg::IDX_MEAS_INC: objRdData <= measIncReg;
					dhp_pkg::IDX_MEAS_USER: objRdData <= measUserReg;
					dhp_pkg::IDX_BAND: objRdData <= band;
					dhp_pkg::IDX_TIMEOUT: objRdData <= {16'h0000, timeoutMs};
					dhp_pkg::IDX_HOME_OFFSET: objRdData <= homeOffset;
					dhp_pkg::IDX_METHOD: objRdData <= 32'(homingMethod);
					dhp_pkg::IDX_EFFORT: objRdData <= controlEffort;
					default: begin
						objRdData <= dhp_pkg::RST_WORD;
						objAck <= 1'b0;
						objError <= 1'b1;
					end
				endcase
			end
		end
	end

	dhp_pos_loop uLoop (
		.mclk(mclk),
		.rstn(rstn),
		.demandInc(demandInc),
		.measInc(encCount),
		.kpGain(kpGain),
		.effortMax(effortMax),
		.effortStepMax(effortStepMax),
		.effort(controlEffort)
	);
endmodule : dhp_homing_monitor
`default_nettype wire

// file: dhp_homing_monitor_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dhp_homing_monitor_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// object access port
	input wire logic [15:0] objIndex,
	input wire logic objWrite,
	input wire logic objRead,
	input wire logic [31:0] objRdData,
	input wire logic objAck,
	input wire logic objError,
	// axis and loop
	input wire logic [31:0] encCount,
	input wire logic [31:0] effortMax,
	input wire logic [31:0] effortStepMax,
	input wire logic signed [31:0] controlEffort,
	// status
	input wire logic moveEn,
	input wire logic [15:0] statusWord,
	input wire logic homingActive
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	logic req;
	logic signed [31:0] prevEff;
	logic [31:0] effAbs;
	logic [31:0] stepAbs;
	assign req = objWrite || objRead;
	assign effAbs = controlEffort[31] ? -controlEffort : controlEffort;
	assign stepAbs = (controlEffort - prevEff) < 0 ? prevEff - controlEffort : controlEffort - prevEff;
	always_ff @(posedge mclk) begin
		if (!rstn)
			prevEff <= 32'sh0000_0000;
		else
			prevEff <= controlEffort;
	end
	AST_ACK_ONE: assert property (req |=> objAck != objError)
		else $error("access not answered exactly once");
	AST_NO_SPURIOUS: assert property (!req |=> !objAck && !objError)
		else $error("answer without access");
	AST_RO_WRITE: assert property (objWrite && (objIndex == dhp_pkg::IDX_MEAS_INC ||
		objIndex == dhp_pkg::IDX_DEMAND || objIndex == dhp_pkg::IDX_MEAS_USER ||
		objIndex == dhp_pkg::IDX_EFFORT) |=> objError && !objAck) else $error("read-only written");
	AST_READ_ENC: assert property (objRead && !objWrite && objIndex == dhp_pkg::IDX_MEAS_INC &&
		$stable(encCount) |=> objRdData == $past(encCount)) else $error("position read wrong");
	AST_EFFORT_CLAMP: assert property (effAbs <= {1'b0, $past(effortMax[30:0])})
		else $error("effort beyond limit");
	AST_EFFORT_STEP: assert property ($past(effortStepMax) != 0 |-> stepAbs <= $past(effortStepMax))
		else $error("effort step too large");
	AST_STATUS_RSVD: assert property ((statusWord & 16'hCFFF) == 16'h0000)
		else $error("stray status bits");
	AST_HOME_STOP: assert property ($rose(statusWord[12]) |-> !moveEn && !$past(moveEn))
		else $error("done while moving");
	AST_ACTIVE_EQ: assert property (homingActive == moveEn)
		else $error("active flag differs from motion");
	AST_DONE_CLEARS: assert property ($rose(moveEn) |-> ##[0:1] !statusWord[12])
		else $error("done kept during new homing");
	// homing only leaves motion through a capture, so done must follow every stop
	AST_DONE_AFTER_STOP: assert property ($fell(homingActive) |=> statusWord[12])
		else $error("motion ended without done");
	cover property ($rose(statusWord[13]));
	cover property ($rose(statusWord[12]));
	cover property (objError);
endmodule : dhp_homing_monitor_chk
bind dhp_homing_monitor dhp_homing_monitor_chk i_chk (.mclk, .rstn, .objIndex, .objWrite,
	.objRead, .objRdData, .objAck, .objError, .encCount, .effortMax, .effortStepMax,
	.controlEffort, .moveEn, .statusWord, .homingActive);
`default_nettype wire

// file: dhp_homing_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dhp_homing_monitor_tb;
	localparam int MSC = 10;
	logic mclk, rstn, objWrite, objRead, homeStart, setPos;
	logic indexPulse, limNeg, limPos, homeSw, objAck, objError;
	logic moveEn, moveDir, moveFast, homingActive;
	logic [15:0] objIndex, kpGain, statusWord;
	logic [31:0] objWrData, objRdData, encCount, demandPos, effortMax, effortStepMax, setVal;
	logic [31:0] rd, a, d;
	logic [4:0] posShift;
	logic signed [31:0] controlEffort;
	integer seed = 121;
	int miscompares = 0;
	int checks = 0;
	int i, n, e;
	int mth[14] = '{1, 2, 3, 4, 5, 6, 7, 8, 11, 17, 18, 33, 34, 35};
	int home[14] = '{16, 192, 96, 112, 128, 112, 96, 112, 128, 9, 199, 48, 64, 50};
	logic dir0[14] = '{0, 1, 1, 1, 1, 1, 1, 0, 0, 0, 1, 0, 1, 1};
	// switch search starts fast, edge and index approach start slow
	logic fast0[14] = '{1, 1, 1, 0, 0, 1, 1, 1, 1, 1, 1, 0, 0, 0};
	dhp_homing_monitor #(.MS_CYCLES(MSC)) i_dut (.mclk, .rstn, .objIndex, .objWrite, .objRead,
		.objWrData, .objRdData, .objAck, .objError, .encCount, .indexPulse, .limNeg, .limPos,
		.homeSw, .demandPos, .posShift, .kpGain, .effortMax, .effortStepMax, .homeStart,
		.moveEn, .moveDir, .moveFast, .controlEffort, .statusWord, .homingActive);
	dhp_axis_model i_axis (.mclk, .rstn, .moveEn, .moveDir, .setPos, .setVal, .encCount,
		.indexPulse, .limNeg, .limPos, .homeSw);
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic fail(input string msg);
		miscompares++;
		$display("unexpected at %0t: %s", $time, msg);
	endtask : fail
	task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp)
			fail($sformatf("%s %h not %h", what, got, exp));
	endtask : cmpWord
	task automatic cmpFlag(input logic got, input logic exp, input string what);
		checks++;
		if (got !== exp)
			fail(what);
	endtask : cmpFlag
	task automatic finish_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	// one access through the object port; the answer is taken just after the edge that accepts the request
	task automatic acc(input logic wr, input logic [15:0] idx, input logic [31:0] v, input logic err);
		@(posedge mclk);
		objWrite <= wr;
		objRead <= !wr;
		objIndex <= idx;
		objWrData <= v;
		@(posedge mclk);
		objWrite <= 1'b0;
		objRead <= 1'b0;
		#1;
		cmpFlag(objError, err, "error flag");
		cmpFlag(objAck, !err, "ack flag");
		rd = objRdData;
	endtask : acc
	task automatic waitSw(input int b, input logic v, input int lim, output int cnt);
		cnt = 0;
		while (statusWord[b] !== v && cnt < lim) begin
			@(posedge mclk);
			#1;
			cnt++;
		end
		if (statusWord[b] !== v) begin
			fail("wait bound used up");
			finish_test();
		end
	endtask : waitSw
	task automatic place(input logic [31:0] v);
		@(posedge mclk);
		setPos <= 1'b1;
		setVal <= v;
		@(posedge mclk);
		setPos <= 1'b0;
	endtask : place
	task automatic pulseStart;
		@(posedge mclk);
		homeStart <= 1'b1;
		@(posedge mclk);
		homeStart <= 1'b0;
		@(posedge mclk);
		#1;
	endtask : pulseStart
	task automatic rst;
		rstn <= 1'b0;
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
	endtask : rst
	task automatic homing(input int k);
		logic [31:0] off;
		off = 32'($random(seed) % 64);
		// methods 5, 6 and 8 start inside the home switch
		place((mth[k] inside {5, 6, 8}) ? 32'd110 : 32'd50);
		acc(1'b1, dhp_pkg::IDX_METHOD, 32'(mth[k]), 1'b0);
		acc(1'b1, dhp_pkg::IDX_HOME_OFFSET, off, 1'b0);
		pulseStart();
		cmpFlag(moveEn, mth[k] != 35, "motion at start");
		cmpFlag(homingActive, mth[k] != 35, "active at start");
		cmpFlag(moveFast, fast0[k], "start speed");
		if (mth[k] != 35)
			cmpFlag(moveDir, dir0[k], "start direction");
		waitSw(dhp_pkg::STAT_HOME_DONE, 1'b1, 3000, n);
		cmpFlag(moveEn, 1'b0, "motion after home");
		acc(1'b0, dhp_pkg::IDX_MEAS_INC, 32'h0000_0000, 1'b0);
		a = rd;
		acc(1'b0, dhp_pkg::IDX_MEAS_USER, 32'h0000_0000, 1'b0);
		cmpWord(a - rd, 32'(home[k]) + off, "zero position");
		$display("homing method %0d done", mth[k]);
	endtask : homing
	initial begin
		{objWrite, objRead, homeStart, setPos} = 4'h0;
		rstn = 1'b0;
		objIndex = 16'h0000;
		{objWrData, setVal, effortStepMax} = 96'h0;
		posShift = 5'h00;
		kpGain = 16'h0100;
		effortMax = 32'h0000_0064;
		demandPos = $random(seed);
		rst();
		for (i = 0; i < 4; i++) begin
			acc(1'b0, i == 0 ? dhp_pkg::IDX_BAND : i == 1 ? dhp_pkg::IDX_TIMEOUT :
				i == 2 ? dhp_pkg::IDX_HOME_OFFSET : dhp_pkg::IDX_METHOD, 32'h0, 1'b0);
			cmpWord(rd, 32'h0000_0000, "reset value");
		end
		acc(1'b0, dhp_pkg::IDX_DEMAND, 32'h0, 1'b0);
		cmpWord(rd, demandPos, "demand read");
		acc(1'b1, dhp_pkg::IDX_MEAS_USER, 32'h0, 1'b1);
		acc(1'b1, dhp_pkg::IDX_EFFORT, 32'h0, 1'b1);
		acc(1'b0, 16'h1234, 32'h0, 1'b1);
		cmpWord(rd, 32'h0000_0000, "unknown read");
		a = $random(seed);
		acc(1'b1, dhp_pkg::IDX_BAND, a, 1'b0);
		acc(1'b0, dhp_pkg::IDX_BAND, 32'h0, 1'b0);
		cmpWord(rd, a, "band readback");
		$display("register test done");
		for (i = 0; i < 14; i++)
			homing(i);
		acc(1'b1, dhp_pkg::IDX_METHOD, 32'h0, 1'b0);
		pulseStart();
		repeat (5) @(posedge mclk);
		#1;
		cmpFlag(moveEn, 1'b0, "method zero moved");
		cmpFlag(statusWord[12], 1'b1, "method zero touched done");
		rst();
		posShift <= 5'd2;
		d = $random(seed) & 32'h0000_FFFF;
		demandPos <= d;
		acc(1'b1, dhp_pkg::IDX_BAND, 32'd5, 1'b0);
		for (i = 0; i < 2; i++) begin
			// set two cycles after the elapsed count passes the timeout
			e = (4 - 3 * i) * MSC + 2;
			acc(1'b1, dhp_pkg::IDX_TIMEOUT, 32'(3 - 3 * i), 1'b0);
			place(d * 4 + (i ? -20 : 20));
			repeat (60) @(posedge mclk);
			#1;
			cmpFlag(statusWord[13], 1'b0, "error at band edge");
			place(d * 4 + (i ? -21 : 21));
			waitSw(dhp_pkg::STAT_FOLLOW_ERR, 1'b1, 200, n);
			cmpFlag(n == e, 1'b1, "timeout length");
			place(d * 4);
			waitSw(dhp_pkg::STAT_FOLLOW_ERR, 1'b0, 4, n);
		end
		$display("tracking test done");
		demandPos <= d + 1000;
		repeat (5) @(posedge mclk);
		#1;
		cmpWord(controlEffort, 32'h0000_0064, "effort clamp");
		acc(1'b0, dhp_pkg::IDX_EFFORT, 32'h0, 1'b0);
		cmpWord(rd, 32'h0000_0064, "effort read");
		effortStepMax <= 32'd3;
		demandPos <= d - 1000;
		repeat (10) @(posedge mclk);
		#1;
		cmpFlag(controlEffort > 0, 1'b1, "effort step");
		repeat (100) @(posedge mclk);
		#1;
		cmpWord(controlEffort, -32'sd100, "effort low clamp");
		$display("effort test done");
		finish_test();
	end
endmodule : dhp_homing_monitor_tb
`default_nettype wire

// file: dhp_pkg.sv
`default_nettype none
package dhp_pkg;
	// clock and the millisecond time base
	localparam int CLK_HZ = 50_000_000;
	localparam int MS_PER_HZ = 1000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / MS_PER_HZ * TICK_MS;

	// object indices
	localparam logic [15:0] IDX_DEMAND = 16'h6062;
	localparam logic [15:0] IDX_MEAS_INC = 16'h6063;
	localparam logic [15:0] IDX_MEAS_USER = 16'h6064;
	localparam logic [15:0] IDX_BAND = 16'h6065;
	localparam logic [15:0] IDX_TIMEOUT = 16'h6066;
	localparam logic [15:0] IDX_HOME_OFFSET = 16'h607C;
	localparam logic [15:0] IDX_METHOD = 16'h6098;
	localparam logic [15:0] IDX_EFFORT = 16'h60FA;

	// reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [15:0] RST_TIMEOUT = 16'h0000;
	localparam logic [7:0] RST_METHOD = 8'h00;

	// status word bits
	localparam int STAT_FOLLOW_ERR = 13;
	localparam int STAT_HOME_DONE = 12;

	// position loop gain has this many fraction bits
	localparam int KP_FRAC = 8;

	// direction: right is increasing encoder count
	localparam logic DIR_LEFT = 1'b0;
	localparam logic DIR_RIGHT = 1'b1;

	// method codes with a meaning of their own
	localparam logic signed [7:0] M_NOIDX_FIRST = 8'sh11;
	localparam logic signed [7:0] M_NOIDX_LAST = 8'sh1E;
	localparam logic signed [7:0] M_NOIDX_SHIFT = 8'sh10;
	localparam logic signed [7:0] M_MOMENT_RIGHT_LAST = 8'sh0A;

	typedef enum {HK_NONE, HK_LIMNEG, HK_LIMPOS, HK_HOMESW, HK_MOMENT, HK_INDEX, HK_CURPOS} dhp_kind_e;

	typedef struct {
		dhp_kind_e kind;
		logic dirFinal;
		logic lvlFinal;
		logic dirInit;
		logic useIdx;
	} dhp_method_s;

	// user units to encoder increments; the position factor is a power of two
	function automatic logic [31:0] toInc(input logic [31:0] v, input logic [4:0] sh);
		return v << sh;
	endfunction : toInc

	// final approach direction and switch level reached at the home edge
	function automatic dhp_method_s decodeMethod(input logic signed [7:0] m);
		dhp_method_s r;
		logic signed [7:0] b;
		r.kind = HK_NONE;
		r.dirFinal = DIR_RIGHT;
		r.lvlFinal = 1'b0;
		r.dirInit = DIR_RIGHT;
		r.useIdx = 1'b1;
		b = m;
		if (m >= M_NOIDX_FIRST && m <= M_NOIDX_LAST) begin
			b = m - M_NOIDX_SHIFT;
			r.useIdx = 1'b0;
		end
		r.dirInit = (b <= M_MOMENT_RIGHT_LAST) ? DIR_RIGHT : DIR_LEFT;
		case (b)
			8'sh01: begin r.kind = HK_LIMNEG; r.dirFinal = DIR_RIGHT; r.lvlFinal = 1'b0; end
			8'sh02: begin r.kind = HK_LIMPOS; r.dirFinal = DIR_LEFT; r.lvlFinal = 1'b0; end
			8'sh03: begin r.kind = HK_HOMESW; r.dirFinal = DIR_LEFT; r.lvlFinal = 1'b0; end
			8'sh04: begin r.kind = HK_HOMESW; r.dirFinal = DIR_RIGHT; r.lvlFinal = 1'b1; end
			8'sh05: begin r.kind = HK_HOMESW; r.dirFinal = DIR_RIGHT; r.lvlFinal = 1'b0; end
			8'sh06: begin r.kind = HK_HOMESW; r.dirFinal = DIR_LEFT; r.lvlFinal = 1'b1; end
			8'sh07: begin r.kind = HK_MOMENT; r.dirFinal = DIR_LEFT; r.lvlFinal = 1'b0; end
			8'sh08: begin r.kind = HK_MOMENT; r.dirFinal = DIR_RIGHT; r.lvlFinal = 1'b1; end
			8'sh09: begin r.kind = HK_MOMENT; r.dirFinal = DIR_LEFT; r.lvlFinal = 1'b1; end
			8'sh0A: begin r.kind = HK_MOMENT; r.dirFinal = DIR_RIGHT; r.lvlFinal = 1'b0; end
			8'sh0B: begin r.kind = HK_MOMENT; r.dirFinal = DIR_RIGHT; r.lvlFinal = 1'b0; end
			8'sh0C: begin r.kind = HK_MOMENT; r.dirFinal = DIR_LEFT; r.lvlFinal = 1'b1; end
			8'sh0D: begin r.kind = HK_MOMENT; r.dirFinal = DIR_RIGHT; r.lvlFinal = 1'b1; end
			8'sh0E: begin r.kind = HK_MOMENT; r.dirFinal = DIR_LEFT; r.lvlFinal = 1'b0; end
			8'sh21: begin r.kind = HK_INDEX; r.dirFinal = DIR_LEFT; end
			8'sh22: begin r.kind = HK_INDEX; r.dirFinal = DIR_RIGHT; end
			8'sh23: r.kind = HK_CURPOS;
			default: r.kind = HK_NONE;
		endcase
		return r;
	endfunction : decodeMethod
endpackage : dhp_pkg
`default_nettype wire

// file: dhp_pos_loop.sv
`timescale 1ns/1ps
`default_nettype none
module dhp_pos_loop (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// loop inputs, both in increments
	input wire logic [31:0] demandInc,
	input wire logic [31:0] measInc,
	// tuning
	input wire logic [15:0] kpGain,
	input wire logic [31:0] effortMax,
	input wire logic [31:0] effortStepMax,
	// loop output
	output logic signed [31:0] effort
);
	typedef logic signed [49:0] dhp_wide_t;

	// limits are taken as magnitudes; top bit of lim is ignored to keep the result in 32 bits
	function automatic dhp_wide_t clampSym(input dhp_wide_t v, input logic [31:0] lim);
		dhp_wide_t l;
		l = dhp_wide_t'({1'b0, lim[30:0]});
		if (v > l) begin
			return l;
		end else if (v < -l) begin
			return -l;
		end
		return v;
	endfunction : clampSym

	logic signed [31:0] posErr;
	dhp_wide_t rawEffort;
	dhp_wide_t stepped;
	dhp_wide_t next_effort;

	always_comb begin
		posErr = signed'(demandInc - measInc);
		rawEffort = (dhp_wide_t'(posErr) * dhp_wide_t'({1'b0, kpGain})) >>> dhp_pkg::KP_FRAC;
		stepped = rawEffort;
		// zero step limit leaves the relative limit off
		if (effortStepMax != dhp_pkg::RST_WORD) begin
			stepped = dhp_wide_t'(effort) + clampSym(rawEffort - dhp_wide_t'(effort), effortStepMax);
		end
		next_effort = clampSym(stepped, effortMax);
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			effort <= signed'(dhp_pkg::RST_WORD);
		end else begin
			effort <= next_effort[31:0];
		end
	end
endmodule : dhp_pos_loop
`default_nettype wire
